// ### vmet_bench.sv
`timescale 1ns/1ps
`include "vmet_defs.vh"
module vmet_bench;
   logic clk_i, rst_i, wr_i, rd_i;
   logic [7:0] addr_i;
   logic [31:0] wdata_i;
   wire [31:0] rdata_o;
   wire lk_valid_i, lk_tagged_i, lk_own_i, gv_valid_i;
   wire lk_done_o, lk_hit_o, lk_learn_o;
   wire [2:0] lk_port_i, lk_pcp_i, gv_port_i, lk_cos_o, lk_pcp_o;
   wire [11:0] lk_vid_i, gv_vid_i, lk_vid_o;
   wire [4:0] lk_fwd_o, lk_tag_o, lk_outer_o;
   int num_errors = 0, n_compared = 0, m_ti = -1;
   int m_vid[257], m_pd[5];
   bit m_val[257], m_prov, m_gv;
   bit [14:0] m_cd[257];
   bit [9:0] m_at[257];
   bit [4:0] m_tr;
   bit [31:0] seed = 32'h229e0073;
   vmet_top i_vmet_top (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .lk_valid_i(lk_valid_i), .lk_port_i(lk_port_i), .lk_own_i(lk_own_i),
      .lk_tagged_i(lk_tagged_i), .lk_vid_i(lk_vid_i), .lk_pcp_i(lk_pcp_i),
      .gv_valid_i(gv_valid_i), .gv_port_i(gv_port_i), .gv_vid_i(gv_vid_i),
      .lk_done_o(lk_done_o), .lk_hit_o(lk_hit_o), .lk_fwd_o(lk_fwd_o),
      .lk_tag_o(lk_tag_o), .lk_outer_o(lk_outer_o), .lk_vid_o(lk_vid_o),
      .lk_cos_o(lk_cos_o), .lk_pcp_o(lk_pcp_o), .lk_learn_o(lk_learn_o));
   vmet_node i_vmet_node (.clk_i(clk_i), .lk_valid_o(lk_valid_i),
      .lk_port_o(lk_port_i), .lk_tagged_o(lk_tagged_i), .lk_vid_o(lk_vid_i),
      .lk_pcp_o(lk_pcp_i), .lk_own_o(lk_own_i), .gv_valid_o(gv_valid_i),
      .gv_port_o(gv_port_i), .gv_vid_o(gv_vid_i));
   initial begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end
   function automatic [31:0] rnd();
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed;
   endfunction
   function automatic int find(int v);
      find = -1;
      for (int i = 256; i >= 0; i--)
         if (m_val[i] && m_vid[i] == v) find = i;
   endfunction
   function automatic [31:0] pexp(int e);
      pexp = m_cd[e];
      for (int p = 0; p < 5; p++)
         if (m_cd[e][3*p +: 3] == 3 && m_pd[p] == m_vid[e]) pexp[3*p +: 3] = 4;
   endfunction
   task stop_test();
      $display("compared %0d, mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task chk(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e) begin
         num_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task fin(input string s);
      $display("test %s ended, mismatches so far %0d", s, num_errors);
   endtask
   task wr(input [7:0] a, input [31:0] d);
      @(posedge clk_i);
      {addr_i, wdata_i, wr_i} <= {a, d, 1'b1};
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask
   task rd(input [7:0] a, output logic [31:0] d);
      @(posedge clk_i);
      {addr_i, rd_i} <= {a, 1'b1};
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 d = rdata_o;
   endtask
   task rd_chk(input [7:0] a, input [31:0] e);
      logic [31:0] d;
      rd(a, d);
      chk(d, e);
   endtask
   task rej(input bit r);
      logic [31:0] d;
      rd(`VMET_A_STAT, d);
      chk(d[1:0], {m_ti >= 0, r});
      wr(`VMET_A_STAT, 32'h1);
   endtask
   task ctl(input [1:0] v);
      wr(`VMET_A_CTRL, v);
      {m_gv, m_prov} = v;
   endtask
   task pchk(input int e);
      wr(`VMET_A_INDEX, e);
      rd_chk(`VMET_A_PORTS, pexp(e));
   endtask
   task automatic mk(input int e, int v);
      bit ok;
      ok = v == 0 ? m_val[e] : !m_val[e] && v < 4095 && find(v) < 0;
      wr(`VMET_A_INDEX, e);
      wr(`VMET_A_VID, v);
      if (ok) {m_val[e], m_vid[e], m_cd[e], m_at[e]} = {v != 0, v, 25'h0};
      rej(!ok);
   endtask
   task automatic pt_wr(input int e, bit [14:0] c);
      wr(`VMET_A_INDEX, e);
      wr(`VMET_A_PORTS, c);
      for (int p = 0; p < 5; p++) if (c[3*p +: 3] == 4) c[3*p +: 3] = 3;
      if (!m_at[e][8]) m_cd[e] = c;
      rej(m_at[e][8]);
   endtask
   task automatic at_wr(input int e, bit [8:0] a);
      bit bad;
      bad = a[8] && m_ti >= 0 && m_ti != e;
      wr(`VMET_A_INDEX, e);
      wr(`VMET_A_ATTR, a);
      for (int p = 0; p < 5 && a[8] && !bad && !m_at[e][8]; p++)
         if (m_cd[e][3*p +: 3] inside {2, 3}) m_pd[p] = m_vid[e];
         else m_cd[e][3*p +: 3] = 1;
      if (a[8] && !bad) m_ti = e;
      if (!a[8] && m_at[e][8]) m_ti = -1;
      m_at[e] = {m_at[e][9], a[8] && !bad, a[7:0]};
      rej(bad);
   endtask
   task automatic gv(input int pt, int v);
      int e, f;
      e = find(v);
      f = -1;
      for (int i = 256; i >= 0; i--)
         if (!m_val[i]) f = i;
      i_vmet_node.reg_vid(pt[2:0], v[11:0]);
      if (m_gv && e >= 0 && !m_at[e][8] && m_cd[e][3*pt +: 3] == 0)
         m_cd[e][3*pt +: 3] = 5;
      if (m_gv && e < 0 && f >= 0)
         {m_val[f], m_vid[f], m_cd[f], m_at[f]} = {1'b1, v, 15'h5 << 3*pt, 10'h200};
   endtask
   task automatic lk(input int pt, bit tg, int v, bit own);
      int e, k, c;
      bit [4:0] mb, tb, tn, f, t, ig;
      bit [9:0] at;
      bit [2:0] pc;
      bit [11:0] ev;
      pc = 3'(rnd());
      k = (tg && v != 0) ? v : m_pd[pt];
      e = find(k);
      at = e >= 0 ? m_at[e] : 10'h0;
      ig = 5'h01 << pt;
      for (int p = 0; p < 5; p++) begin
         c = e >= 0 ? m_cd[e][3*p +: 3] : 0;
         mb[p] = e >= 0 && c != 1 && (c > 1 || m_tr[p]);
         tb[p] = c inside {2, 5, 6} || m_tr[p];
         tn[p] = c == 7;
      end
      f = own ? mb : mb & ~ig;
      t = tb;
      ev = k;
      if (!own && (mb & ig) != 0 && at[1:0] == 2) f = 0;
      if (!own && (mb & ig) != 0 && at[8]) begin
         t = tg ? 5'h1f : 5'h00;
         if (tg && v == 0) ev = 0;
         else if (tg) f = mb & tb & ~ig;
      end
      if (own) {t, ev} = m_ti >= 0 ? 17'h1f000 : {5'h00, ev};
      i_vmet_node.send(pt[2:0], tg, v[11:0], pc, own);
      #1 chk(lk_done_o, 1);
      chk(lk_hit_o, e >= 0);
      chk(lk_fwd_o, f);
      chk(lk_tag_o & f, t & f);
      chk(lk_outer_o, m_prov ? f & ~tn : 5'h00);
      chk(lk_cos_o, at[6] ? at[5:3] : pc);
      chk(lk_pcp_o, at[6] && at[7] ? at[5:3] : pc);
      chk(lk_learn_o, e >= 0 && at[2]);
      if (e >= 0) chk(lk_vid_o, ev);
   endtask
   initial begin
      repeat (20000) @(posedge clk_i);
      num_errors++;
      stop_test();
   end
   initial begin
      for (int p = 0; p < 5; p++) m_pd[p] = 1;
      {rst_i, addr_i, wdata_i, wr_i, rd_i} = {1'b1, 42'h0};
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      rd_chk(`VMET_A_CTRL, 0);
      rd_chk(8'h30, 1);
      rd_chk(`VMET_A_VID, 0);
      rd_chk(8'hfc, 0);
      fin("reset");
      mk(0, 0);
      mk(0, 4095);
      mk(0, 1);
      mk(256, 4094);
      rd_chk(`VMET_A_VID, 32'h80000ffe);
      mk(1, 1);
      mk(0, 7);
      mk(256, 0);
      fin("table");
      mk(2, 5);
      wr(`VMET_A_TRUNK, 5'h14);
      m_tr = 5'h14;
      pt_wr(2, {3'h0, 3'h5, 3'h1, 3'h2, 3'h4});
      {m_pd[0]} = 5;
      wr(8'h20, 5);
      pchk(2);
      lk(1, 1, 5, 0);
      lk(0, 0, 0, 0);
      lk(0, 1, 0, 0);
      lk(2, 1, 5, 0);
      lk(3, 1, 77, 0);
      for (int i = 0; i < 4; i++) begin
         at_wr(2, {1'b0, i[1], i[0], 3'h6, i[0], 2'h0});
         lk(1, 1, 5, 0);
      end
      fin("membership");
      mk(3, 9);
      pt_wr(3, {9'h0, 3'h6, 3'h2});
      at_wr(3, 9'h002);
      lk(0, 1, 9, 0);
      lk(3, 1, 9, 0);
      at_wr(3, 9'h003);
      lk(0, 1, 9, 0);
      wr(`VMET_A_PRIM, 5);
      rd_chk(`VMET_A_PRIM, 5);
      at_wr(3, 9'h001);
      rd_chk(`VMET_A_PRIM, 9);
      wr(`VMET_A_PRIM, 5);
      rej(1);
      at_wr(3, 9'h000);
      ctl(1);
      pt_wr(2, {3'h0, 3'h7, 3'h1, 3'h2, 3'h3});
      lk(1, 1, 5, 0);
      fin("private and provider");
      ctl(0);
      gv(3, 9);
      pchk(3);
      ctl(2);
      gv(3, 9);
      pchk(3);
      gv(2, 5);
      pchk(2);
      gv(1, 100);
      wr(`VMET_A_INDEX, 1);
      rd_chk(`VMET_A_ATTR, 32'h200);
      ctl(0);
      fin("registration");
      at_wr(2, 9'h100);
      rd_chk(8'h24, 5);
      pchk(2);
      pt_wr(2, 15'h0);
      at_wr(3, 9'h100);
      lk(0, 0, 0, 0);
      lk(0, 1, 0, 0);
      lk(0, 1, 5, 0);
      lk(0, 0, 0, 1);
      at_wr(2, 9'h000);
      pchk(2);
      lk(0, 0, 0, 1);
      fin("transparent");
      stop_test();
   end
endmodule

// ### vmet_chk_monitor.sv
`timescale 1ns/1ps
`include "vmet_defs.vh"
module vmet_chk (
   input wire clk_i,
   input wire rst_i,
   input wire lk_valid_i,
   input wire [`VMET_PIW-1:0] lk_port_i,
   input wire [`VMET_KW-1:0] lk_pcp_i,
   input wire lk_own_i,
   input wire lk_done_o,
   input wire lk_hit_o,
   input wire [`VMET_NPORT-1:0] lk_fwd_o,
   input wire [`VMET_NPORT-1:0] lk_tag_o,
   input wire [`VMET_NPORT-1:0] lk_outer_o,
   input wire [`VMET_VW-1:0] lk_vid_o,
   input wire [`VMET_KW-1:0] lk_cos_o,
   input wire [`VMET_KW-1:0] lk_pcp_o,
   input wire lk_learn_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   property p_done; lk_valid_i |=> lk_done_o; endproperty
   a_done: assert property (p_done)
      else $error("lookup answer missing");
   property p_idle; !lk_valid_i |=> !lk_done_o; endproperty
   a_idle: assert property (p_idle)
      else $error("lookup answer without request");
   property p_miss; lk_done_o && !lk_hit_o |-> (lk_fwd_o | lk_tag_o) == 5'h00;
   endproperty
   a_miss: assert property (p_miss)
      else $error("unknown vlan forwarded");
   property p_cos; lk_done_o && !lk_hit_o |-> lk_cos_o == $past(lk_pcp_i);
   endproperty
   a_cos: assert property (p_cos)
      else $error("class changed without entry");
   property p_upd; lk_done_o && lk_pcp_o != $past(lk_pcp_i) |->
      lk_cos_o == lk_pcp_o; endproperty
   a_upd: assert property (p_upd)
      else $error("tag priority rewritten without force");
   property p_learn; lk_learn_o |-> lk_hit_o; endproperty
   a_learn: assert property (p_learn)
      else $error("learning without entry");
   property p_ingress; lk_done_o && !$past(lk_own_i) && $past(lk_port_i) < 3'h5
      |-> !lk_fwd_o[$past(lk_port_i)]; endproperty
   a_ingress: assert property (p_ingress)
      else $error("frame sent back to ingress port");
   property p_outer; (lk_outer_o & ~lk_fwd_o) == 5'h00; endproperty
   a_outer: assert property (p_outer)
      else $error("outer tag on port not forwarded");
   property p_own; lk_done_o && $past(lk_own_i) && lk_tag_o != 5'h00 |->
      lk_vid_o == 12'h000 && lk_tag_o == 5'h1f; endproperty
   a_own: assert property (p_own)
      else $error("own frame tag wrong");
endmodule
bind vmet_top vmet_chk i_vmet_chk (
   .clk_i(clk_i), .rst_i(rst_i), .lk_valid_i(lk_valid_i),
   .lk_port_i(lk_port_i), .lk_pcp_i(lk_pcp_i), .lk_own_i(lk_own_i),
   .lk_done_o(lk_done_o), .lk_hit_o(lk_hit_o), .lk_fwd_o(lk_fwd_o),
   .lk_tag_o(lk_tag_o), .lk_outer_o(lk_outer_o), .lk_vid_o(lk_vid_o),
   .lk_cos_o(lk_cos_o), .lk_pcp_o(lk_pcp_o), .lk_learn_o(lk_learn_o)
);

// ### vmet_defs.vh
`ifndef VMET_DEFS_VH
`define VMET_DEFS_VH
`define VMET_NPORT 5
`define VMET_NENT 257
`define VMET_IW 9
`define VMET_VW 12
`define VMET_KW 3
`define VMET_CW 15
`define VMET_AW 10
`define VMET_DW 32
`define VMET_ADW 8
`define VMET_PIW 3
`define VMET_ONE 5'h01
`define VMET_ALL 5'h1f
`define VMET_NONE5 5'h00
`define VMET_VID_ZERO 12'h000
`define VMET_VID_MIN 12'h001
`define VMET_VID_MAX 12'hffe
`define VMET_PDVID_RST 12'h001
`define VMET_IDX_MAX 9'h100
`define VMET_IDX_RST 9'h000
`define VMET_CODES_RST 15'h0000
`define VMET_ATTR_RST 10'h000
`define VMET_ATTR_DYN 10'h200
`define VMET_ZERO32 32'h00000000
`define VMET_A_CTRL 8'h00
`define VMET_A_INDEX 8'h04
`define VMET_A_VID 8'h08
`define VMET_A_PORTS 8'h0c
`define VMET_A_ATTR 8'h10
`define VMET_A_PRIM 8'h14
`define VMET_A_STAT 8'h18
`define VMET_A_TRUNK 8'h1c
`define VMET_A_PD_HI 3'h1
`define VMET_C_NONE 3'h0
`define VMET_C_FORB 3'h1
`define VMET_C_TAG 3'h2
`define VMET_C_UNT 3'h3
`define VMET_C_UDEF 3'h4
`define VMET_C_REG 3'h5
`define VMET_C_TRUNK 3'h6
`define VMET_C_TUN 3'h7
`define VMET_PV_NONE 2'h0
`define VMET_PV_PRIM 2'h1
`define VMET_PV_ISO 2'h2
`define VMET_PV_COMM 2'h3
`define VMET_F_PV 1:0
`define VMET_F_LEARN 2
`define VMET_F_PRIO 5:3
`define VMET_F_FORCE 6
`define VMET_F_UPD 7
`define VMET_F_TRANS 8
`define VMET_F_DYN 9
`define VMET_F_VALID 31
`define VMET_F_VID 11:0
`define VMET_F_PROV 0
`define VMET_F_GVRP 1
`define VMET_F_REJ 0
`define VMET_F_TACT 1
`define VMET_F_TIDX 24:16
`define VMET_F_IDX 8:0
`define VMET_F_PORTS 14:0
`define VMET_F_TRUNK 4:0
`define VMET_F_APD 7:5
`define VMET_F_APORT 4:2
`endif

// ### vmet_node.sv
`timescale 1ns/1ps
module vmet_node (
   input wire clk_i,
   output reg lk_valid_o,
   output reg [2:0] lk_port_o,
   output reg lk_tagged_o,
   output reg [11:0] lk_vid_o,
   output reg [2:0] lk_pcp_o,
   output reg lk_own_o,
   output reg gv_valid_o,
   output reg [2:0] gv_port_o,
   output reg [11:0] gv_vid_o
);
   initial begin
      {lk_valid_o, lk_port_o, lk_tagged_o, lk_vid_o, lk_pcp_o} = 20'h0;
      {lk_own_o, gv_valid_o, gv_port_o, gv_vid_o} = 17'h0;
   end
   // Fields other than the port are scrambled once a request is gone
   task send(input [2:0] p, input t, input [11:0] v, input [2:0] c, input o);
      @(posedge clk_i);
      lk_valid_o <= 1'b1;
      {lk_port_o, lk_tagged_o, lk_vid_o, lk_pcp_o, lk_own_o} <= {p, t, v, c, o};
      @(posedge clk_i);
      lk_valid_o <= 1'b0;
      {lk_tagged_o, lk_vid_o, lk_pcp_o, lk_own_o} <= ~{t, v, c, o};
   endtask
   task reg_vid(input [2:0] p, input [11:0] v);
      @(posedge clk_i);
      {gv_valid_o, gv_port_o, gv_vid_o} <= {1'b1, p, v};
      @(posedge clk_i);
      {gv_valid_o, gv_vid_o} <= {1'b0, ~v};
   endtask
endmodule

// ### vmet_top.v
`timescale 1ns/1ps
`include "vmet_defs.vh"
// Behaviour
// - Entry identifiers are accepted only from 1 to 4094.
// - Table holds 257 entries; identifier fixed until entry deleted.
// - Provider role adds outer service tags; customer role is plain.
// - Entries record static or dynamic origin; dynamic only with GVRP on.
// - Isolated secondary private VLAN blocks forwarding among its ports, except for transparent-id frames and own frames.
// - Community secondary forwards normally and stores its primary id.
// - One primary per group; primary uses its own identifier.
// - Enabling transparency sets tagged and untagged member ports' default id to that VLAN.
// - Untagged frames on transparent ports leave untagged to others.
// - Identifier zero frames go to other transparent ports tagged zero.
// - Transparent-id frames go only to other tagged-member ports, tagged with it.
// - Own real-time frames tagged zero in transparent mode, else untagged.
// - Enabling transparency forbids non-members; its ports become locked.
// - At most one VLAN may be transparent at a time.
// - Disabling transparency leaves port membership untouched.
// - Per-entry enable controls unicast source learning.
// - Per-entry forced priority overrides class of service; no-force keeps.
// - Update bit writes the forced priority into the tag field.
// - Forbidden ports never join through GVRP or trunk setting.
// - Tagged members send tagged; trunk ports belong to every VLAN that does not forbid them.
// - Untagged members send untagged; default id classifies untagged input.
// - Untagged reads as default kind exactly when default id matches.
// - Identifier zero frames are untagged but keep their priority.
module vmet_top (
   input wire clk_i,
   input wire rst_i,
   input wire [`VMET_ADW-1:0] addr_i,
   input wire [`VMET_DW-1:0] wdata_i,
   input wire wr_i,
   input wire rd_i,
   output wire [`VMET_DW-1:0] rdata_o,
   input wire lk_valid_i,
   input wire [`VMET_PIW-1:0] lk_port_i,
   input wire lk_tagged_i,
   input wire [`VMET_VW-1:0] lk_vid_i,
   input wire [`VMET_KW-1:0] lk_pcp_i,
   input wire lk_own_i,
   input wire gv_valid_i,
   input wire [`VMET_PIW-1:0] gv_port_i,
   input wire [`VMET_VW-1:0] gv_vid_i,
   output wire lk_done_o,
   output wire lk_hit_o,
   output wire [`VMET_NPORT-1:0] lk_fwd_o,
   output wire [`VMET_NPORT-1:0] lk_tag_o,
   output wire [`VMET_NPORT-1:0] lk_outer_o,
   output wire [`VMET_VW-1:0] lk_vid_o,
   output wire [`VMET_KW-1:0] lk_cos_o,
   output wire [`VMET_KW-1:0] lk_pcp_o,
   output wire lk_learn_o
);

   function [`VMET_IW-1:0] vmet_enc;
      input [`VMET_NENT-1:0] v;
      integer i;
      begin
         vmet_enc = `VMET_IDX_RST;
         for (i = `VMET_NENT - 1; i >= 0; i = i - 1) begin
            if (v[i])
               vmet_enc = i[`VMET_IW-1:0];
         end
      end
   endfunction

   reg [`VMET_VW-1:0] vid_mem [0:`VMET_NENT-1];
   reg [`VMET_CW-1:0] code_mem [0:`VMET_NENT-1];
   reg [`VMET_AW-1:0] attr_mem [0:`VMET_NENT-1];
   reg [`VMET_VW-1:0] prim_mem [0:`VMET_NENT-1];
   reg [`VMET_NENT-1:0] valid_ff;
   reg prov_ff;
   reg gvrp_ff;
   reg [`VMET_IW-1:0] idx_ff;
   reg [`VMET_NPORT-1:0] trunk_ff;
   reg tact_ff;
   reg [`VMET_IW-1:0] tidx_ff;
   reg rej_ff;
   reg [`VMET_DW-1:0] rdata_ff;
   reg lk_done_ff;
   reg lk_hit_ff;
   reg [`VMET_NPORT-1:0] lk_fwd_ff;
   reg [`VMET_NPORT-1:0] lk_tag_ff;
   reg [`VMET_NPORT-1:0] lk_outer_ff;
   reg [`VMET_VW-1:0] lk_vid_ff;
   reg [`VMET_KW-1:0] lk_cos_ff;
   reg [`VMET_KW-1:0] lk_pcp_ff;
   reg lk_learn_ff;
   reg nxt_hit;
   reg [`VMET_NPORT-1:0] nxt_fwd;
   reg [`VMET_NPORT-1:0] nxt_tag;
   reg [`VMET_NPORT-1:0] nxt_outer;
   reg [`VMET_VW-1:0] nxt_vid;
   reg [`VMET_KW-1:0] nxt_cos;
   reg [`VMET_KW-1:0] nxt_pcp;
   reg nxt_learn;
   reg [`VMET_DW-1:0] nxt_rdata;

   wire [`VMET_NPORT*`VMET_VW-1:0] pdvid_w;
   wire [`VMET_NPORT-1:0] lk_oh = `VMET_ONE << lk_port_i;
   wire [`VMET_NPORT-1:0] gv_oh = `VMET_ONE << gv_port_i;
   wire [`VMET_NPORT-1:0] pd_oh = `VMET_ONE << addr_i[`VMET_F_APORT];
   wire lk_pok = |lk_oh;
   wire [`VMET_VW-1:0] lk_pd = lk_pok ?
      pdvid_w[lk_port_i*`VMET_VW +: `VMET_VW] : `VMET_VID_ZERO;
   wire lk_vz = lk_tagged_i & (lk_vid_i == `VMET_VID_ZERO);
   // Priority-only tags classify like untagged frames
   wire [`VMET_VW-1:0] lk_key =
      (lk_tagged_i & !lk_vz) ? lk_vid_i : lk_pd;

   wire [`VMET_NENT-1:0] lk_hv;
   wire [`VMET_NENT-1:0] sw_hv;
   wire [`VMET_NENT-1:0] gv_hv;
   genvar e;
   generate
      for (e = 0; e < `VMET_NENT; e = e + 1) begin : g_ent
         assign lk_hv[e] = valid_ff[e] & (vid_mem[e] == lk_key);
         assign sw_hv[e] = valid_ff[e] &
            (vid_mem[e] == wdata_i[`VMET_F_VID]);
         assign gv_hv[e] = valid_ff[e] & (vid_mem[e] == gv_vid_i);
      end
   endgenerate

   wire [`VMET_IW-1:0] lk_idx = vmet_enc(lk_hv);
   wire lk_hit = |lk_hv;
   wire [`VMET_CW-1:0] lk_codes = code_mem[lk_idx];
   wire [`VMET_AW-1:0] lk_attr = attr_mem[lk_idx];
   wire sel_ok = idx_ff <= `VMET_IDX_MAX;
   wire sel_v = sel_ok & valid_ff[idx_ff];
   wire [`VMET_CW-1:0] sel_codes = code_mem[idx_ff];
   wire [`VMET_AW-1:0] sel_attr = attr_mem[idx_ff];
   wire [`VMET_VW-1:0] sel_vid = vid_mem[idx_ff];
   wire [`VMET_VW-1:0] sel_prim = prim_mem[idx_ff];
   wire sel_tr = tact_ff & (tidx_ff == idx_ff);
   wire sel_pri = sel_attr[`VMET_F_PV] == `VMET_PV_PRIM;
   wire [`VMET_IW-1:0] gv_idx = vmet_enc(gv_hv);
   wire gv_hit = |gv_hv;
   wire [`VMET_CW-1:0] gv_codes = code_mem[gv_idx];
   wire [`VMET_IW-1:0] free_idx = vmet_enc(~valid_ff);
   wire free_any = |(~valid_ff);

   wire w_vid = wr_i & (addr_i == `VMET_A_VID);
   wire vid_ok = (wdata_i[`VMET_F_VID] >= `VMET_VID_MIN) &
      (wdata_i[`VMET_F_VID] <= `VMET_VID_MAX);
   wire do_crt = w_vid & sel_ok & !sel_v & vid_ok & !(|sw_hv);
   wire do_del = w_vid & sel_v &
      (wdata_i[`VMET_F_VID] == `VMET_VID_ZERO);
   wire w_prt = wr_i & (addr_i == `VMET_A_PORTS);
   wire do_prt = w_prt & sel_v & !sel_tr;
   wire w_att = wr_i & (addr_i == `VMET_A_ATTR);
   wire t_in = wdata_i[`VMET_F_TRANS];
   wire do_att = w_att & sel_v;
   wire do_ten = do_att & t_in & !tact_ff;
   wire do_tdis = do_att & !t_in & sel_tr;
   wire w_prm = wr_i & (addr_i == `VMET_A_PRIM);
   wire do_prm = w_prm & sel_v & !sel_pri;
   wire w_pd = wr_i & (addr_i[`VMET_F_APD] == `VMET_A_PD_HI);
   wire sw_mem = do_crt | do_del | do_prt | do_att | do_prm;
   wire rej = (w_vid & !do_crt & !do_del) | (w_prt & !do_prt) |
      (w_att & !sel_v) | (do_att & t_in & tact_ff & !sel_tr) |
      (w_prm & !do_prm) | (w_pd & !vid_ok);
   wire gv_go = gv_valid_i & gvrp_ff & !sw_mem & (|gv_oh);
   wire gv_tr = tact_ff & (tidx_ff == gv_idx);
   wire gv_upd = gv_go & gv_hit & !gv_tr;
   wire gv_vok = (gv_vid_i >= `VMET_VID_MIN) & (gv_vid_i <= `VMET_VID_MAX);
   wire gv_crt = gv_go & !gv_hit & gv_vok & free_any;
   wire [`VMET_AW-1:0] att_new =
      {sel_attr[`VMET_F_DYN], 1'b0, wdata_i[`VMET_F_UPD:0]};

   wire [`VMET_NPORT-1:0] lk_mem;
   wire [`VMET_NPORT-1:0] lk_tgm;
   wire [`VMET_NPORT-1:0] lk_tun;
   wire [`VMET_NPORT-1:0] ten_pd;
   wire [`VMET_CW-1:0] wr_codes;
   wire [`VMET_CW-1:0] ten_codes;
   wire [`VMET_CW-1:0] rd_codes;
   wire [`VMET_CW-1:0] gv_upd_codes;
   wire [`VMET_CW-1:0] gv_new_codes;
   genvar p;
   generate
      for (p = 0; p < `VMET_NPORT; p = p + 1) begin : g_port
         wire [`VMET_KW-1:0] lc = lk_codes[p*`VMET_KW +: `VMET_KW];
         wire [`VMET_KW-1:0] sc = sel_codes[p*`VMET_KW +: `VMET_KW];
         wire [`VMET_KW-1:0] wc = wdata_i[p*`VMET_KW +: `VMET_KW];
         wire [`VMET_KW-1:0] gc = gv_codes[p*`VMET_KW +: `VMET_KW];
         wire lf = lc == `VMET_C_FORB;
         reg [`VMET_VW-1:0] pd_ff;
         assign lk_mem[p] = !lf & ((lc == `VMET_C_TAG) |
            (lc == `VMET_C_UNT) | (lc == `VMET_C_REG) |
            (lc == `VMET_C_TRUNK) | (lc == `VMET_C_TUN) |
            trunk_ff[p]);
         assign lk_tgm[p] = !lf & ((lc == `VMET_C_TAG) |
            (lc == `VMET_C_REG) | (lc == `VMET_C_TRUNK) |
            trunk_ff[p]);
         assign lk_tun[p] = lc == `VMET_C_TUN;
         assign wr_codes[p*`VMET_KW +: `VMET_KW] =
            (wc == `VMET_C_UDEF) ? `VMET_C_UNT : wc;
         assign ten_pd[p] = (sc == `VMET_C_TAG) | (sc == `VMET_C_UNT);
         assign ten_codes[p*`VMET_KW +: `VMET_KW] =
            ten_pd[p] ? sc : `VMET_C_FORB;
         assign rd_codes[p*`VMET_KW +: `VMET_KW] =
            ((sc == `VMET_C_UNT) & (pd_ff == sel_vid)) ?
            `VMET_C_UDEF : sc;
         assign gv_upd_codes[p*`VMET_KW +: `VMET_KW] =
            (gv_oh[p] & (gc == `VMET_C_NONE)) ?
            `VMET_C_REG : gc;
         assign gv_new_codes[p*`VMET_KW +: `VMET_KW] =
            gv_oh[p] ? `VMET_C_REG : `VMET_C_NONE;
         assign pdvid_w[p*`VMET_VW +: `VMET_VW] = pd_ff;
         always @(posedge clk_i or posedge rst_i) begin
            if (rst_i) begin
               pd_ff <= `VMET_PDVID_RST;
            end else if (do_ten & ten_pd[p]) begin
               pd_ff <= sel_vid;
            end else if (w_pd & pd_oh[p] & vid_ok) begin
               pd_ff <= wdata_i[`VMET_F_VID];
            end
         end
      end
   endgenerate

   // Table storage; created entries are fully initialised, so no reset
   always @(posedge clk_i) begin
      if (do_crt) begin
         vid_mem[idx_ff] <= wdata_i[`VMET_F_VID];
         code_mem[idx_ff] <= `VMET_CODES_RST;
         attr_mem[idx_ff] <= `VMET_ATTR_RST;
         prim_mem[idx_ff] <= `VMET_VID_ZERO;
      end else if (do_prt) begin
         code_mem[idx_ff] <= wr_codes;
      end else if (do_ten) begin
         code_mem[idx_ff] <= ten_codes;
      end else if (gv_upd) begin
         code_mem[gv_idx] <= gv_upd_codes;
      end else if (gv_crt) begin
         vid_mem[free_idx] <= gv_vid_i;
         code_mem[free_idx] <= gv_new_codes;
         attr_mem[free_idx] <= `VMET_ATTR_DYN;
         prim_mem[free_idx] <= `VMET_VID_ZERO;
      end
      if (do_att) begin
         attr_mem[idx_ff] <= att_new;
      end
      if (do_att & (wdata_i[`VMET_F_PV] == `VMET_PV_PRIM)) begin
         prim_mem[idx_ff] <= sel_vid;
      end else if (do_prm) begin
         prim_mem[idx_ff] <= wdata_i[`VMET_F_VID];
      end
   end

   wire lk_trin = tact_ff & lk_hit & (lk_idx == tidx_ff) &
      (|(lk_mem & lk_oh));

   always @* begin
      nxt_hit = lk_valid_i & lk_hit;
      nxt_vid = vid_mem[lk_idx];
      nxt_fwd = lk_mem & ~lk_oh;
      nxt_tag = lk_tgm;
      if ((lk_attr[`VMET_F_PV] == `VMET_PV_ISO) &&
          (|(lk_mem & lk_oh))) begin
         nxt_fwd = `VMET_NONE5;
      end
      if (lk_own_i) begin
         nxt_fwd = lk_mem;
         nxt_tag = tact_ff ? `VMET_ALL : `VMET_NONE5;
         if (tact_ff) begin
            nxt_vid = `VMET_VID_ZERO;
         end
      end else if (lk_trin) begin
         if (!lk_tagged_i) begin
            nxt_tag = `VMET_NONE5;
         end else if (lk_vz) begin
            nxt_tag = `VMET_ALL;
            nxt_vid = `VMET_VID_ZERO;
         end else begin
            nxt_fwd = lk_tgm & ~lk_oh;
            nxt_tag = `VMET_ALL;
         end
      end
      if (!nxt_hit) begin
         nxt_fwd = `VMET_NONE5;
         nxt_tag = `VMET_NONE5;
      end
      nxt_cos = (lk_hit & lk_attr[`VMET_F_FORCE]) ?
         lk_attr[`VMET_F_PRIO] : lk_pcp_i;
      nxt_pcp = (lk_hit & lk_attr[`VMET_F_FORCE] & lk_attr[`VMET_F_UPD]) ?
         lk_attr[`VMET_F_PRIO] : lk_pcp_i;
      nxt_learn = nxt_hit & lk_attr[`VMET_F_LEARN];
      nxt_outer = prov_ff ? (nxt_fwd & ~lk_tun) : `VMET_NONE5;
   end

   always @* begin
      nxt_rdata = `VMET_ZERO32;
      case (addr_i)
         `VMET_A_CTRL: begin
            nxt_rdata[`VMET_F_PROV] = prov_ff;
            nxt_rdata[`VMET_F_GVRP] = gvrp_ff;
         end
         `VMET_A_INDEX: nxt_rdata[`VMET_F_IDX] = idx_ff;
         `VMET_A_VID: begin
            nxt_rdata[`VMET_F_VALID] = sel_v;
            nxt_rdata[`VMET_F_VID] = sel_v ? sel_vid : `VMET_VID_ZERO;
         end
         `VMET_A_PORTS:
            nxt_rdata[`VMET_F_PORTS] = sel_v ? rd_codes : `VMET_CODES_RST;
         `VMET_A_ATTR: begin
            nxt_rdata[`VMET_AW-1:0] = sel_v ? sel_attr : `VMET_ATTR_RST;
            nxt_rdata[`VMET_F_TRANS] = sel_tr;
         end
         `VMET_A_PRIM:
            nxt_rdata[`VMET_F_VID] = !sel_v ? `VMET_VID_ZERO :
               (sel_pri ? sel_vid : sel_prim);
         `VMET_A_STAT: begin
            nxt_rdata[`VMET_F_REJ] = rej_ff;
            nxt_rdata[`VMET_F_TACT] = tact_ff;
            nxt_rdata[`VMET_F_TIDX] = tidx_ff;
         end
         `VMET_A_TRUNK: nxt_rdata[`VMET_F_TRUNK] = trunk_ff;
         default: begin
            if ((addr_i[`VMET_F_APD] == `VMET_A_PD_HI) && (|pd_oh)) begin
               nxt_rdata[`VMET_F_VID] =
                  pdvid_w[addr_i[`VMET_F_APORT]*`VMET_VW +: `VMET_VW];
            end
         end
      endcase
   end

   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         valid_ff <= {`VMET_NENT{1'b0}};
         prov_ff <= 1'b0;
         gvrp_ff <= 1'b0;
         idx_ff <= `VMET_IDX_RST;
         trunk_ff <= `VMET_NONE5;
         tact_ff <= 1'b0;
         tidx_ff <= `VMET_IDX_RST;
         rej_ff <= 1'b0;
         rdata_ff <= `VMET_ZERO32;
         lk_done_ff <= 1'b0;
         lk_hit_ff <= 1'b0;
         lk_fwd_ff <= `VMET_NONE5;
         lk_tag_ff <= `VMET_NONE5;
         lk_outer_ff <= `VMET_NONE5;
         lk_vid_ff <= `VMET_VID_ZERO;
         lk_cos_ff <= {`VMET_KW{1'b0}};
         lk_pcp_ff <= {`VMET_KW{1'b0}};
         lk_learn_ff <= 1'b0;
      end else begin
         if (wr_i && (addr_i == `VMET_A_CTRL)) begin
            prov_ff <= wdata_i[`VMET_F_PROV];
            gvrp_ff <= wdata_i[`VMET_F_GVRP];
         end
         if (wr_i && (addr_i == `VMET_A_INDEX)) begin
            idx_ff <= wdata_i[`VMET_F_IDX];
         end
         if (wr_i && (addr_i == `VMET_A_TRUNK)) begin
            trunk_ff <= wdata_i[`VMET_F_TRUNK];
         end
         if (do_crt) begin
            valid_ff[idx_ff] <= 1'b1;
         end else if (do_del) begin
            valid_ff[idx_ff] <= 1'b0;
         end else if (gv_crt) begin
            valid_ff[free_idx] <= 1'b1;
         end
         if (do_ten) begin
            tact_ff <= 1'b1;
            tidx_ff <= idx_ff;
         end else if (do_tdis | (do_del & sel_tr)) begin
            tact_ff <= 1'b0;
         end
         // A new rejection wins over a clear in the same cycle
         if (rej) begin
            rej_ff <= 1'b1;
         end else if (wr_i && (addr_i == `VMET_A_STAT) &&
                      wdata_i[`VMET_F_REJ]) begin
            rej_ff <= 1'b0;
         end
         rdata_ff <= rd_i ? nxt_rdata : `VMET_ZERO32;
         lk_done_ff <= lk_valid_i;
         lk_hit_ff <= nxt_hit;
         lk_fwd_ff <= nxt_fwd;
         lk_tag_ff <= nxt_tag;
         lk_outer_ff <= nxt_outer;
         lk_vid_ff <= nxt_vid;
         lk_cos_ff <= nxt_cos;
         lk_pcp_ff <= nxt_pcp;
         lk_learn_ff <= nxt_learn;
      end
   end

   assign rdata_o = rdata_ff;
   assign lk_done_o = lk_done_ff;
   assign lk_hit_o = lk_hit_ff;
   assign lk_fwd_o = lk_fwd_ff;
   assign lk_tag_o = lk_tag_ff;
   assign lk_outer_o = lk_outer_ff;
   assign lk_vid_o = lk_vid_ff;
   assign lk_cos_o = lk_cos_ff;
   assign lk_pcp_o = lk_pcp_ff;
   assign lk_learn_o = lk_learn_ff;

endmodule
